/* include/rate_gen_pkg.sv */
package rate_gen_pkg;

	// Register indexes and byte addresses
	localparam logic [7:0] RATE_SELECT_IDX = 8'h0D;
	localparam logic [7:0] MISC_IDX = 8'h0C;
	localparam logic [7:0] GEN_STATUS_IDX = 8'h1F;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] RATE_SELECT_ADDR = 8'h34;
	localparam logic [ADDR_W-1:0] MISC_ADDR = 8'h30;
	localparam logic [ADDR_W-1:0] GEN_STATUS_ADDR = 8'h7C;

	// Field positions
	localparam int PRESCALE_LSB = 6;
	localparam int TX_RATE_LSB = 3;
	localparam int RX_RATE_LSB = 0;
	localparam int SLOW_MODE_BIT = 1;
	localparam int ST_HALTED_BIT = 0;
	localparam int ST_TX_EN_BIT = 1;
	localparam int ST_RX_EN_BIT = 2;
	localparam int ST_SLOW_BIT = 3;

	// Reset values
	localparam logic [1:0] PRESCALE_RESET = 2'h0;
	localparam logic [2:0] RATE_RESET = 3'h0;

	// Division constants
	localparam int PRE_CW = 4;
	localparam logic [PRE_CW-1:0] PRE_RATIO_0 = 4'h1;
	localparam logic [PRE_CW-1:0] PRE_RATIO_1 = 4'h3;
	localparam logic [PRE_CW-1:0] PRE_RATIO_2 = 4'h4;
	localparam logic [PRE_CW-1:0] PRE_RATIO_3 = 4'hD;
	localparam int SLOW_DIV = 16;
	localparam int OVERSAMPLE = 16;
	localparam int RATE_SEL_W = 3;
	localparam int RATE_CW = 7;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [1:0] prescale;
		logic [2:0] tx_rate;
		logic [2:0] rx_rate;
	} rate_select_t;

	typedef struct packed {
		logic tx;
		logic rx;
	} dir_pair_t;

endpackage

/* hdl/prescale_divider.sv */
`timescale 1ns/10ps
module prescale_divider
	import rate_gen_pkg::*;
#(
	parameter int CW = PRE_CW
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Step and ratio
	input wire logic step_in,
	input wire logic [CW-1:0] ratio_in,
	// Divided tick
	output logic tick_out
);

	logic [CW-1:0] count;
	logic [CW-1:0] active;
	wire terminal = (count == active - CW'(1));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= '0;
			active <= PRE_RATIO_0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= step_in & terminal;
			if (step_in) begin
				if (terminal) begin
					count <= '0;
					active <= ratio_in;
				end else begin
					count <= count + CW'(1);
				end
			end
		end
	end

endmodule // prescale_divider

/* hdl/binary_rate_divider.sv */
`timescale 1ns/10ps
module binary_rate_divider
	import rate_gen_pkg::*;
#(
	parameter int SW = RATE_SEL_W,
	parameter int CW = RATE_CW
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Step and select
	input wire logic step_in,
	input wire logic [SW-1:0] sel_in,
	// Divided tick
	output logic tick_out
);

	logic [CW-1:0] count;
	logic [SW-1:0] active;
	wire [CW:0] span = (CW+1)'(1) << active;
	wire [CW-1:0] last = CW'(span - (CW+1)'(1));
	wire terminal = (count == last);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= '0;
			active <= RATE_RESET;
			tick_out <= 1'b0;
		end else begin
			tick_out <= step_in & terminal;
			if (step_in) begin
				if (terminal) begin
					count <= '0;
					active <= sel_in;
				end else begin
					count <= count + CW'(1);
				end
			end
		end
	end

endmodule // binary_rate_divider

/* hdl/sci_baud_rate_generator.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Functional notes
// - prescaler field divides by 1,3,4,13
// - one prescaled clock feeds both dividers
// - transmit field divides by two^field
// - receive field divides independently by two^field
// - bit rate is fosc/(16*prescale*divide)
// - receiver tick runs at sixteen times rate
// - STOP halts the whole rate generator
// - transmit freezes in STOP, later resumes
// - reception in STOP stops, character discarded
// - WAIT leaves serial timing fully running
// - reset clears prescaler, rate fields unspecified
// - slow mode slows generator input sixteenfold
module sci_baud_rate_generator
	import rate_gen_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// AXI4-Lite write address
	input wire logic awvalid_in,
	output logic awready_out,
	input wire logic [ADDR_W-1:0] awaddr_in,
	input wire logic [2:0] awprot_in,
	// AXI4-Lite write data
	input wire logic wvalid_in,
	output logic wready_out,
	input wire logic [31:0] wdata_in,
	input wire logic [3:0] wstrb_in,
	// AXI4-Lite write response
	output logic bvalid_out,
	input wire logic bready_in,
	output logic [1:0] bresp_out,
	// AXI4-Lite read address
	input wire logic arvalid_in,
	output logic arready_out,
	input wire logic [ADDR_W-1:0] araddr_in,
	input wire logic [2:0] arprot_in,
	// AXI4-Lite read data
	output logic rvalid_out,
	input wire logic rready_in,
	output logic [31:0] rdata_out,
	output logic [1:0] rresp_out,
	// Core power modes and serial enables
	input wire logic stop_mode_in,
	input wire logic wait_mode_in,
	input wire logic tx_enable_bit_in,
	input wire logic rx_enable_bit_in,
	// Serial engine timing
	output logic tx_bit_tick_out,
	output logic rx_sample_tick_out,
	output logic rx_discard_out,
	output logic halted_out
);

	////////////////////////////////////////////////////////////////////
	// Register storage

	rate_select_t rate_sel;
	logic slow_clock_mode;
	logic stop_q;

	// Stop edge, same clock as the core so no synchroniser
	wire stop_entry = stop_mode_in & ~stop_q;
	wire run = ~stop_mode_in;
	dir_pair_t enables;
	assign enables.tx = tx_enable_bit_in;
	assign enables.rx = rx_enable_bit_in;

	////////////////////////////////////////////////////////////////////
	// Write channel

	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire aw_take = awvalid_in & awready_out;
	wire w_take = wvalid_in & wready_out;
	wire have_aw = aw_held | aw_take;
	wire have_w = w_held | w_take;
	wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : awaddr_in;
	wire [31:0] wr_data = w_held ? w_data : wdata_in;
	wire [3:0] wr_strb = w_held ? w_strb : wstrb_in;
	wire wr_fire = have_aw & have_w & ~bvalid_out;
	wire wr_lane0 = wr_fire & wr_strb[0];
	wire wr_rate_hit = (wr_addr == RATE_SELECT_ADDR);
	wire wr_misc_hit = (wr_addr == MISC_ADDR);
	wire wr_stat_hit = (wr_addr == GEN_STATUS_ADDR);
	wire wr_mapped = wr_rate_hit | wr_misc_hit | wr_stat_hit;
	wire wr_rate_load = wr_lane0 & wr_rate_hit;
	wire wr_misc_load = wr_lane0 & wr_misc_hit;
	wire [1:0] wr_code = wr_mapped ? RESP_OKAY : RESP_SLVERR;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			awready_out <= 1'b0;
			wready_out <= 1'b0;
			bvalid_out <= 1'b0;
			bresp_out <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr_in;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= wdata_in;
				w_strb <= wstrb_in;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out <= wr_code;
			end else if (bvalid_out & bready_in) begin
				bvalid_out <= 1'b0;
			end
			// Registered ready idles low every other cycle, no comb path
			awready_out <= ~have_aw & ~awready_out;
			wready_out <= ~have_w & ~wready_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rate_sel.prescale <= PRESCALE_RESET;
			rate_sel.tx_rate <= RATE_RESET;
			rate_sel.rx_rate <= RATE_RESET;
			slow_clock_mode <= 1'b0;
			stop_q <= 1'b0;
		end else begin
			stop_q <= stop_mode_in;
			if (wr_rate_load) begin
				rate_sel <= rate_select_t'(wr_data[7:0]);
			end
			// Entry clear wins over a same-cycle write
			// slow cleared on STOP
			if (stop_entry) begin
				slow_clock_mode <= 1'b0;
			end else if (wr_misc_load) begin
				slow_clock_mode <= wr_data[SLOW_MODE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel

	wire ar_take = arvalid_in & arready_out;
	wire rd_rate_hit = (araddr_in == RATE_SELECT_ADDR);
	wire rd_misc_hit = (araddr_in == MISC_ADDR);
	wire rd_stat_hit = (araddr_in == GEN_STATUS_ADDR);
	wire rd_mapped = rd_rate_hit | rd_misc_hit | rd_stat_hit;
	wire [7:0] misc_view = 8'(slow_clock_mode) << SLOW_MODE_BIT;
	wire [7:0] stat_view = (8'(stop_q) << ST_HALTED_BIT)
		| (8'(enables.tx) << ST_TX_EN_BIT)
		| (8'(enables.rx) << ST_RX_EN_BIT)
		| (8'(slow_clock_mode) << ST_SLOW_BIT);
	wire [7:0] rd_byte = rd_rate_hit ? 8'(rate_sel)
		: rd_misc_hit ? misc_view
		: rd_stat_hit ? stat_view : 8'h00;
	wire [31:0] rd_word = {24'h00_0000, rd_byte};
	wire [1:0] rd_code = rd_mapped ? RESP_OKAY : RESP_SLVERR;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			arready_out <= 1'b0;
			rvalid_out <= 1'b0;
			rdata_out <= 32'h0000_0000;
			rresp_out <= RESP_OKAY;
		end else begin
			arready_out <= ~rvalid_out & ~arready_out & ~ar_take;
			if (ar_take) begin
				rvalid_out <= 1'b1;
				rdata_out <= rd_word;
				rresp_out <= rd_code;
			end else if (rvalid_out & rready_in) begin
				rvalid_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slow mode input divider

	logic [3:0] slow_count;
	wire slow_tc = (slow_count == 4'(SLOW_DIV - 1));
	// STOP halts the base step
	// Only the source and the rx output gate stop; the other stages drain
	wire base_step = run & (~slow_clock_mode | slow_tc);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			slow_count <= 4'h0;
		end else if (run) begin
			slow_count <= slow_clock_mode ? slow_count + 4'h1 : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Common prescaler

	logic [PRE_CW-1:0] pre_ratio;
	logic pre_tick;

	assign pre_ratio = (rate_sel.prescale == 2'h0) ? PRE_RATIO_0
		: (rate_sel.prescale == 2'h1) ? PRE_RATIO_1
		: (rate_sel.prescale == 2'h2) ? PRE_RATIO_2 : PRE_RATIO_3;

	prescale_divider #(
		.CW(PRE_CW)
	) u_prescale (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.step_in(base_step),
		.ratio_in(pre_ratio),
		.tick_out(pre_tick)
	);

	////////////////////////////////////////////////////////////////////
	// Per-direction rate dividers

	logic [1:0] dir_en;
	logic [1:0][RATE_SEL_W-1:0] dir_sel;
	logic [1:0] dir_tick;

	assign dir_en = {enables.tx, enables.rx};
	assign dir_sel = {rate_sel.tx_rate, rate_sel.rx_rate};

	genvar d;
	generate
		for (d = 0; d < 2; d++) begin : g_dir
			// No STOP gate here, so a pulse in flight is kept
			// shared prescaled step
			wire step = pre_tick & dir_en[d];
			binary_rate_divider #(
				.SW(RATE_SEL_W),
				.CW(RATE_CW)
			) u_div (
				.clk_in(clk_in),
				.rst_in(rst_in),
				.step_in(step),
				.sel_in(dir_sel[d]),
				.tick_out(dir_tick[d])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Output ticks

	// Frozen count holds the bit phase across STOP
	logic [3:0] tx_phase;
	logic [3:0] next_tx_phase;
	// in-flight pulses drain, none lost
	// Ungated so the bit phase shifts by exactly the halt
	wire tx_x16 = dir_tick[1];
	wire tx_phase_tc = (tx_phase == 4'(OVERSAMPLE - 1));
	wire tx_bit = tx_x16 & tx_phase_tc;
	wire rx_x16 = dir_tick[0] & run;
	wire rx_drop = stop_entry & enables.rx;

	assign next_tx_phase = tx_phase_tc ? 4'h0 : tx_phase + 4'h1;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_phase <= 4'h0;
			tx_bit_tick_out <= 1'b0;
			rx_sample_tick_out <= 1'b0;
			rx_discard_out <= 1'b0;
			halted_out <= 1'b0;
		end else begin
			if (tx_x16) begin
				tx_phase <= next_tx_phase;
			end
			tx_bit_tick_out <= tx_bit;
			rx_sample_tick_out <= rx_x16;
			rx_discard_out <= rx_drop;
			halted_out <= stop_mode_in;
		end
	end

endmodule // sci_baud_rate_generator

/* verification/tick_monitor.sv */
`timescale 1ns/10ps
// Serial engine stand-in: counts ticks and their spacing
module tick_monitor (
	// Clock and tick
	input wire logic clk_in,
	input wire logic tick_in,
	// Last spacing and running count
	output logic [31:0] period_out = 32'h0000_0000,
	output logic [31:0] count_out = 32'h0000_0000
);
	logic [31:0] gap = 32'h0000_0001;
	always @(posedge clk_in) begin
		gap <= (tick_in === 1'b1) ? 32'h0000_0001 : gap + 1;
		if (tick_in === 1'b1) begin
			period_out <= gap;
			count_out <= count_out + 1;
		end
	end
endmodule // tick_monitor

/* verification/rate_gen_asserts.sv */
`timescale 1ns/10ps
module rate_gen_checker (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Bus answers
	input wire logic bvalid_out,
	input wire logic bready_in,
	input wire logic [1:0] bresp_out,
	input wire logic arvalid_in,
	input wire logic arready_out,
	input wire logic rvalid_out,
	input wire logic rready_in,
	input wire logic [31:0] rdata_out,
	// Modes and ticks
	input wire logic stop_mode_in,
	input wire logic tx_enable_bit_in,
	input wire logic rx_enable_bit_in,
	input wire logic tx_bit_tick_out,
	input wire logic rx_sample_tick_out,
	input wire logic rx_discard_out,
	input wire logic halted_out
);
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Margin covers the tick pipeline
	halt_follow_a: assert property (
		stop_mode_in |=> halted_out) else $error("halt flag late");
	stop_quiet_a: assert property (
		stop_mode_in [*6] |-> !tx_bit_tick_out && !rx_sample_tick_out)
		else $error("tick during stop");
	discard_pulse_a: assert property (
		$rose(stop_mode_in) && rx_enable_bit_in |=> rx_discard_out)
		else $error("discard missing");
	discard_entry_a: assert property (
		rx_discard_out |-> $past(stop_mode_in) && !$past(stop_mode_in, 2))
		else $error("stray discard");
	tx_off_a: assert property (
		!tx_enable_bit_in [*6] |-> !tx_bit_tick_out) else $error("tx tick off");
	rx_off_a: assert property (
		!rx_enable_bit_in [*6] |-> !rx_sample_tick_out) else $error("rx tick off");
	tx_gap_a: assert property (
		tx_bit_tick_out |=> !tx_bit_tick_out [*8]) else $error("tx ticks close");
	b_hold_a: assert property (
		bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
		else $error("write answer dropped");
	r_hold_a: assert property (
		rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
		else $error("read answer dropped");
	rd_lat_a: assert property (
		arvalid_in && arready_out |=> rvalid_out) else $error("read late");
	discard_c: cover property (rx_discard_out);
	stop_c: cover property (halted_out [*8]);
	read_c: cover property (rvalid_out && rready_in);
endmodule // rate_gen_checker

bind sci_baud_rate_generator rate_gen_checker rate_gen_checker_inst (.*);

/* verification/sci_baud_rate_generator_test.sv */
`timescale 1ns/10ps
module sci_baud_rate_generator_test import rate_gen_pkg::*; ;
	logic clk_in = 0;
	logic rst_in = 1;
	logic awvalid_in = 0, wvalid_in = 0, bready_in = 0;
	logic arvalid_in = 0, rready_in = 0, stop_mode_in = 0, wait_mode_in = 0;
	logic tx_enable_bit_in = 1, rx_enable_bit_in = 1;
	logic [7:0] awaddr_in = 0, araddr_in = 0;
	logic [3:0] wstrb_in = 4'hF;
	logic [31:0] wdata_in = 0, rdata_out, rd, tx_p, rx_p, tx_n, rx_n, rx_c;
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic tx_bit_tick_out, rx_sample_tick_out, rx_discard_out, halted_out;
	logic [1:0] bresp_out, rresp_out, rs;
	int failures = 0, check_count = 0, cyc = 0, prev_tx = 16;
	sci_baud_rate_generator sci_baud_rate_generator_inst (.*,
		.awprot_in(3'h0), .arprot_in(3'h0));
	tick_monitor tick_monitor_tx (.clk_in(clk_in),
		.tick_in(tx_bit_tick_out), .period_out(tx_p), .count_out(tx_n));
	tick_monitor tick_monitor_rx (.clk_in(clk_in),
		.tick_in(rx_sample_tick_out), .period_out(rx_p), .count_out(rx_n));
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	task automatic end_sim;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Hang guard well above the longest sequence
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Late bready keeps the answer-hold checks busy
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		awvalid_in <= 1;
		wvalid_in <= 1;
		awaddr_in <= a;
		wdata_in <= d;
		do begin
			@(posedge clk_in);
			if (awready_out) awvalid_in <= 0;
			if (wready_out) wvalid_in <= 0;
		end while ((awvalid_in && !awready_out) || (wvalid_in && !wready_out));
		@(posedge clk_in);
		bready_in <= 1;
		do @(posedge clk_in); while (!bvalid_out);
		bready_in <= 0;
		rs = bresp_out;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk_in);
		arvalid_in <= 1;
		araddr_in <= a;
		do @(posedge clk_in); while (!arready_out);
		arvalid_in <= 0;
		@(posedge clk_in);
		rready_in <= 1;
		do @(posedge clk_in); while (!rvalid_out);
		rready_in <= 0;
		rd = rdata_out;
		rs = rresp_out;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdr(RATE_SELECT_ADDR);
		chk(rd, 0);
		rdr(8'h40);
		chk(rs, RESP_SLVERR);
		chk(rd, 0);
		wr(8'h44, 32'h0000_00FF);
		chk(rs, RESP_SLVERR);
		wstrb_in <= 4'h0;
		wr(RATE_SELECT_ADDR, 32'h0000_00FF);
		wstrb_in <= 4'hF;
		chk(rs, RESP_OKAY);
		rdr(RATE_SELECT_ADDR);
		chk(rd, 0);
		$display("reset test done");
	endtask
	// Old divider must finish its count first
	task automatic t_rate(input logic [7:0] v, input int rxe, input int txe);
		wr(RATE_SELECT_ADDR, {24'h0, v});
		chk(rs, RESP_OKAY);
		repeat (4 * txe + 4 * prev_tx + 20) @(posedge clk_in);
		chk(rx_p, rxe);
		chk(tx_p, txe);
		rdr(RATE_SELECT_ADDR);
		chk(rd, {24'h0, v});
		chk(rs, RESP_OKAY);
		prev_tx = txe;
		$display("rate test %h done", v);
	endtask
	task automatic t_stop;
		int n;
		n = 0;
		do @(posedge clk_in); while (tx_bit_tick_out !== 1'b1);
		stop_mode_in <= 1;
		repeat (8) begin
			@(posedge clk_in);
			if (rx_discard_out === 1'b1) n++;
		end
		chk(n, 1);
		chk(halted_out, 1);
		rx_c = rx_n + tx_n;
		repeat (300) @(posedge clk_in);
		chk(rx_n + tx_n, rx_c);
		rdr(GEN_STATUS_ADDR);
		chk(rd, 32'h0000_0007);
		rdr(MISC_ADDR);
		chk(rd, 0);
		@(posedge clk_in);
		stop_mode_in <= 0;
		$display("stop test done");
	endtask
	// Halt mid-bit: the bit gap grows by exactly the halted cycles
	task automatic t_resume;
		do @(posedge clk_in); while (tx_bit_tick_out !== 1'b1);
		repeat (5) @(posedge clk_in);
		stop_mode_in <= 1;
		repeat (40) @(posedge clk_in);
		stop_mode_in <= 0;
		do @(posedge clk_in); while (tx_bit_tick_out !== 1'b1);
		@(posedge clk_in);
		chk(tx_p, 16 + 40);
		$display("resume test done");
	endtask
	task automatic t_wait;
		@(posedge clk_in);
		wait_mode_in <= 1;
		rx_c = rx_n;
		repeat (100) @(posedge clk_in);
		chk(rx_n - rx_c, 100);
		tx_enable_bit_in <= 0;
		rx_enable_bit_in <= 0;
		repeat (8) @(posedge clk_in);
		rx_c = rx_n + tx_n;
		repeat (100) @(posedge clk_in);
		chk(rx_n + tx_n, rx_c);
		wait_mode_in <= 0;
		$display("wait test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_in);
		rst_in <= 0;
		t_reset();
		t_rate(8'h00, 1, 16);
		t_rate(8'h4A, 12, 96);
		t_rate(8'h9F, 512, 512);
		t_rate(8'hE1, 26, 3328);
		wr(MISC_ADDR, 32'h0000_0002);
		t_rate(8'h00, 16, 256);
		rdr(GEN_STATUS_ADDR);
		chk(rd, 32'h0000_000E);
		t_stop();
		t_rate(8'h00, 1, 16);
		t_resume();
		t_wait();
		end_sim();
	end
endmodule // sci_baud_rate_generator_test
